// File: verilog/slp_cfg.svh
`ifndef SLP_CFG_SVH
`define SLP_CFG_SVH

// ------------------------------------------------------------
// Register map of the slave port
// ------------------------------------------------------------
`define SLP_PAGE_OFS   16'hfffc
`define SLP_SERCFG_OFS 16'hfff8
`define SLP_STATUS_OFS 16'hfff9
`define SLP_USER_PAGE  8'h80
`define SLP_PAGE_1B    6'h3f
`define SLP_PAGE_RST   32'h0000_0000
`define SLP_MEM_DEPTH  256

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define SLP_CFG_TWO_BYTE 0
`define SLP_CFG_SPI_SEL  1
`define SLP_DEV_ADDR_RST 7'h58
`define SLP_STRAP_BIT    2
`define SLP_TWO_BYTE_RST 1'b0
`define SLP_SPI_SEL_RST  1'b0

`endif

// File: verilog/slp_pkg.sv
package slp_pkg;

  // Reset sequence stages.
  typedef enum logic [2:0] {
    RS_LOAD = 3'b001,
    RS_FIX  = 3'b010,
    RS_DONE = 3'b100
  } slp_rst_e;

  // Bus engine states.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV  = 6'h02,
    ST_ACK  = 6'h04,
    ST_WRB  = 6'h08,
    ST_RDB  = 6'h10,
    ST_RACK = 6'h20
  } slp_i2c_e;

  // Port setup handed from the reset sequence to the bus side.
  typedef struct packed {
    logic [6:0] dev_base;
    logic       two_byte;
    logic       spi_sel;
    logic       fail;
  } slp_cfg_s;

endpackage

// File: verilog/slp_port.sv
`include "slp_cfg.svh"
// Function
// - Device has a boot master port and a slave register port.
// - Slave port is enabled only after load and patch stages finish.
// - Sixteen bit offsets; user registers only in upper half.
// - Own page register; full or paged offset addressing.
// - Seven bit bus address from register, default 1011000b.
// - Two select pins give address bits 0 and 1, held static.
// - Strap latched after reset gives default of address bit 2.
// - One or two offset bytes; every offset bit addresses.
// - One byte mode: page gives high byte, offset gives low.
// - Page register at offset byte 0xFC, written in one burst.
// - Two byte mode takes full address; page at 0xFFFC.
// - Pointer advances by one after each data byte.
// - Works at 100kHz, 400kHz and 1MHz bus clock.
// - Port settings and protocol change by one burst write.
// - Select and input pins double as address pins.
// - Sequence completes on failure and status shows it.
module slp_port (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             link_clk,
  input  wire logic             scl_pin,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire logic             select_or_addr0_pin,
  input  wire logic             serial_in_or_addr1_pin,
  input  wire logic             gpio_strap_pin,
  input  wire logic             load_done,
  input  wire logic             hotfix_done,
  input  wire logic             load_fail,
  input  wire logic             load_cfg_valid,
  input  wire slp_pkg::slp_cfg_s load_cfg,
  output logic                  port_ready,
  output logic                  spi_selected
);
  import slp_pkg::*;

  // ----------------------------------------------------------
  // Reset sequence, reference clock side
  // ----------------------------------------------------------
  slp_rst_e rs_st;
  slp_cfg_s ref_cfg;
  logic     strap_s1;
  logic     strap_s2;

  // Strap pin is synchronised before it is caught.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      strap_s1 <= gpio_strap_pin;
      strap_s2 <= strap_s1;
    end
  end

  // Stages run load, patch, done; a failed load still completes.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rs_st   <= RS_LOAD;
      ref_cfg <= '0;
    end else begin
      case (rs_st)
        RS_LOAD: begin
          if (load_done) begin
            rs_st        <= RS_FIX;
            ref_cfg.fail <= load_fail;
            if (load_cfg_valid) begin
              ref_cfg.dev_base <= load_cfg.dev_base;
              ref_cfg.two_byte <= load_cfg.two_byte;
              ref_cfg.spi_sel  <= load_cfg.spi_sel;
            end else begin
              ref_cfg.dev_base <= `SLP_DEV_ADDR_RST
                                  | {4'h0, strap_s2, 2'h0};
              ref_cfg.two_byte <= `SLP_TWO_BYTE_RST;
              ref_cfg.spi_sel  <= `SLP_SPI_SEL_RST;
            end
          end
        end
        RS_FIX: begin
          if (hotfix_done) begin
            rs_st <= RS_DONE;
          end
        end
        RS_DONE: begin
          rs_st <= RS_DONE;
        end
        default: begin
          rs_st <= RS_LOAD;
        end
      endcase
    end
  end

  // Enable level follows the final stage.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_ready <= 1'b0;
    end else begin
      port_ready <= (rs_st == RS_DONE);
    end
  end

  a_enable_order : assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(port_ready) |-> $past(rs_st) == RS_DONE && $past(rs_st, 2) != RS_LOAD)
    else $error("port enabled before patch stage");

  a_addr_default : assert property (@(posedge ref_clk) disable iff (sys_rst)
    rs_st == RS_LOAD && load_done && !load_cfg_valid
    |=> ref_cfg.dev_base[6:3] == 4'hb && ref_cfg.dev_base[1:0] == 2'h0)
    else $error("default bus address wrong");

  // ----------------------------------------------------------
  // Link side synchronisers
  // ----------------------------------------------------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic       scl_d;
  logic       sda_d;
  logic       en_s1;
  logic       en_s2;

  // Pins and enable each pass two flops; scl_d and sda_d are edge taps.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= 4'h3;
      pin_s2 <= 4'h3;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
    end else begin
      pin_s1 <= {serial_in_or_addr1_pin, select_or_addr0_pin, sda_in, scl_pin};
      pin_s2 <= pin_s1;
      scl_d  <= pin_s2[0];
      sda_d  <= pin_s2[1];
      en_s1  <= port_ready;
      en_s2  <= en_s1;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // Bus conditions from the synchronised lines.
  assign scl_s    = pin_s2[0];
  assign sda_s    = pin_s2[1];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c  = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c   = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------------------------
  // Port setup capture and registers
  // ----------------------------------------------------------
  logic       en_l;
  logic [6:0] dev_base;
  logic [7:0] sercfg;
  logic [7:0] status;
  logic [6:0] dev_addr;

  // The setup word is stable before the enable level arrives.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_l     <= 1'b0;
      dev_base <= `SLP_DEV_ADDR_RST;
      status   <= 8'h00;
    end else if (en_s2 && !en_l) begin
      en_l     <= 1'b1;
      dev_base <= ref_cfg.dev_base;
      status   <= {7'h00, ref_cfg.fail};
    end
  end

  // Select pins supply the two low address bits.
  assign dev_addr = {dev_base[6:2], pin_s2[3], pin_s2[2]};

  slp_i2c_e    st;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic        rw;
  logic [1:0]  ofs_cnt;
  logic [15:0] ptr;
  logic [31:0] page;
  logic [7:0]  mem [0:`SLP_MEM_DEPTH-1];
  logic        two_byte;
  logic [1:0]  need;
  logic        byte_done;
  logic        ofs_ld;
  logic        data_wr;
  logic        rd_load;
  logic [15:0] eff;
  logic [7:0]  rd_val;

  // Maps the pointer to a register address.
  function automatic logic [15:0] map_addr(input logic [15:0] p, input logic tb);
    if (!tb && p[7:2] == `SLP_PAGE_1B) begin
      map_addr = `SLP_PAGE_OFS | {14'h0, p[1:0]};
    end else begin
      map_addr = p;
    end
  endfunction

  // Read data for an address; unmapped bytes read zero.
  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    if (a[15:2] == `SLP_PAGE_OFS >> 2) begin
      rd_byte = page[8*a[1:0] +: 8];
    end else if (a == `SLP_SERCFG_OFS) begin
      rd_byte = sercfg;
    end else if (a == `SLP_STATUS_OFS) begin
      rd_byte = status;
    end else if (a[15:8] == `SLP_USER_PAGE) begin
      rd_byte = mem[a[7:0]];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // Event decode for the engine.
  assign two_byte  = sercfg[`SLP_CFG_TWO_BYTE];
  assign need      = two_byte ? 2'd2 : 2'd1;
  assign byte_done = scl_fall && bitcnt == 4'd8;
  assign ofs_ld    = st == ST_WRB && byte_done && ofs_cnt < need;
  assign data_wr   = st == ST_WRB && byte_done && ofs_cnt == need;
  assign rd_load   = scl_fall && ((st == ST_ACK && rw) || st == ST_RACK);
  assign eff       = map_addr(ptr, two_byte);

  // Byte that a read returns at the current pointer.
  always_comb begin
    rd_val = rd_byte(eff);
  end

  // ----------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------
  // Answers only its own address while enabled in bus mode.
  // A protocol switch waits for the bus to go idle, so its own byte is still acknowledged.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st      <= ST_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      tx      <= 8'h00;
      rw      <= 1'b0;
      ofs_cnt <= 2'd0;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else if (!en_l || (sercfg[`SLP_CFG_SPI_SEL] && st == ST_IDLE)) begin
      st     <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      st     <= ST_DEV;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st     <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_DEV, ST_WRB: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          if (byte_done && st == ST_DEV) begin
            if (shreg[7:1] == dev_addr) begin
              st      <= ST_ACK;
              sda_oe  <= 1'b1;
              sda_out <= 1'b0;
              rw      <= shreg[0];
              if (!shreg[0]) begin
                ofs_cnt <= 2'd0;
              end
            end else begin
              st <= ST_IDLE;
            end
          end else if (byte_done) begin
            st      <= ST_ACK;
            sda_oe  <= 1'b1;
            sda_out <= 1'b0;
            if (ofs_ld) begin
              ofs_cnt <= ofs_cnt + 2'd1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (rw) begin
              st      <= ST_RDB;
              sda_out <= rd_val[7];
              tx      <= {rd_val[6:0], 1'b0};
            end else begin
              st     <= ST_WRB;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_RDB: begin
          if (scl_fall) begin
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'd7) begin
              st     <= ST_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_out <= tx[7];
              tx      <= {tx[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            st <= ST_IDLE;
          end else if (scl_fall) begin
            st      <= ST_RDB;
            bitcnt  <= 4'h0;
            sda_oe  <= 1'b1;
            sda_out <= rd_val[7];
            tx      <= {rd_val[6:0], 1'b0};
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // Offset bytes build the pointer; every data byte advances it.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr <= 16'h0000;
    end else if (ofs_ld && !two_byte) begin
      ptr <= {page[15:8], shreg};
    end else if (ofs_ld && ofs_cnt == 2'd0) begin
      ptr[15:8] <= shreg;
    end else if (ofs_ld) begin
      ptr[7:0] <= shreg;
    end else if (data_wr || rd_load) begin
      ptr <= ptr + 16'h0001;
    end
  end

  localparam logic [31:0] PAGE_RST = `SLP_PAGE_RST;

  // Page register byte lanes.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_page
      always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
          page[8*i +: 8] <= PAGE_RST[8*i +: 8];
        end else if (data_wr && eff == (`SLP_PAGE_OFS | i)) begin
          page[8*i +: 8] <= shreg;
        end
      end
    end
  endgenerate

  // Port setup register; a burst write changes mode or protocol.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sercfg       <= 8'h00;
      spi_selected <= 1'b0;
    end else if (en_s2 && !en_l) begin
      sercfg       <= {6'h00, ref_cfg.spi_sel, ref_cfg.two_byte};
      spi_selected <= ref_cfg.spi_sel;
    end else if (data_wr && eff == `SLP_SERCFG_OFS) begin
      sercfg       <= {6'h00, shreg[1:0]};
      spi_selected <= shreg[`SLP_CFG_SPI_SEL];
    end
  end

  // User register image in the upper half of the space.
  always_ff @(posedge link_clk) begin
    if (data_wr && eff[15:8] == `SLP_USER_PAGE) begin
      mem[eff[7:0]] <= shreg;
    end
  end

  // ----------------------------------------------------------
  // Checks on the link side
  // ----------------------------------------------------------
  a_port_gated : assert property (@(posedge link_clk) disable iff (sys_rst)
    !en_l |-> st == ST_IDLE && !sda_oe)
    else $error("port active before enable");

  a_foreign_addr : assert property (@(posedge link_clk) disable iff (sys_rst)
    st == ST_DEV && byte_done && shreg[7:1] != dev_addr && !start_c && !stop_c
    && en_l && !sercfg[1] |=> st == ST_IDLE && !sda_oe)
    else $error("foreign address answered");

  a_pin_bits : assert property (@(posedge link_clk) disable iff (sys_rst)
    en_l |-> dev_addr[1:0] == $past({serial_in_or_addr1_pin, select_or_addr0_pin}, 2))
    else $error("select pins not in address");

  a_ptr_step : assert property (@(posedge link_clk) disable iff (sys_rst)
    data_wr || rd_load |=> ptr == $past(ptr) + 16'h0001)
    else $error("pointer did not advance");

  a_ptr_paged : assert property (@(posedge link_clk) disable iff (sys_rst)
    ofs_ld && !two_byte |=> ptr == {$past(page[15:8]), $past(shreg)})
    else $error("paged address wrong");

  a_ptr_full : assert property (@(posedge link_clk) disable iff (sys_rst)
    ofs_ld && two_byte && ofs_cnt == 2'd1 |=> ptr[7:0] == $past(shreg))
    else $error("full offset low byte wrong");

  a_page_write : assert property (@(posedge link_clk) disable iff (sys_rst)
    data_wr && eff == 16'hfffd |=> page[15:8] == $past(shreg))
    else $error("page byte not stored");

  a_ack_drive : assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(st == ST_ACK) |-> sda_oe && !sda_out)
    else $error("acknowledge not driven low");

endmodule // slp_port

// File: verification/slp_host.sv
// Host bus master: drives the bus clock and pulls data low, open-drain style.
module slp_host #(
  parameter int QTR = 6
) (
  input  wire logic ref_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // The clock stands high and data is released between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // A quarter bit is QTR reference cycles, about 400 kHz on the bus.
  task automatic qw(input int n);
    repeat (n * QTR) @(negedge ref_clk);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_low = 1'b0;
    qw(1);
    scl = 1'b1;
    qw(1);
    sda_low = 1'b1;
    qw(1);
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus rests.
  task automatic stop();
    sda_low = 1'b1;
    qw(1);
    scl = 1'b1;
    qw(1);
    sda_low = 1'b0;
    qw(2);
  endtask

  // One bit: data set in the low phase, wire sampled mid high phase.
  task automatic bit_io(input logic o, output logic i);
    qw(1);
    sda_low = ~o;
    qw(1);
    scl = 1'b1;
    qw(1);
    i = sda_w;
    qw(1);
    scl = 1'b0;
  endtask

  // Sends a byte most significant bit first and returns the acknowledge bit.
  task automatic wbyte(input logic [7:0] b, output logic nack);
    logic s;
    for (int k = 7; k >= 0; k--) bit_io(b[k], s);
    bit_io(1'b1, nack);
  endtask

  // Reads a byte; the last byte of a read is not acknowledged.
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
    bit_io(last, s);
  endtask
endmodule  // slp_host

// File: verification/slp_port_tb.sv
`include "slp_cfg.svh"
module slp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import slp_pkg::*;

  localparam logic [6:0] BASE = `SLP_DEV_ADDR_RST;
  localparam logic [7:0] AW   = {BASE[6:3], 3'b111, 1'b0};
  // Bus address loaded at the second reset; the select pins still give its two low bits.
  localparam logic [6:0] LOADED = 7'h2c;
  localparam logic [7:0] AW2    = {LOADED[6:2], 2'b11, 1'b0};

  logic       ref_clk     = 1'b0;
  logic       link_clk    = 1'b0;
  logic       sys_rst     = 1'b1;
  logic       load_done   = 1'b0;
  logic       hotfix_done = 1'b0;
  logic       load_fail   = 1'b0;
  logic       cfg_valid   = 1'b0;
  slp_cfg_s   load_cfg    = '0;
  logic       pin0        = 1'b1;
  logic       pin1        = 1'b1;
  logic       strap       = 1'b1;
  logic       scl;
  logic       sda_low;
  logic       sda_w;
  logic       sda_out;
  logic       sda_oe;
  logic       port_ready;
  logic       spi_selected;
  logic [7:0] rx[$];
  logic [7:0] cur_aw      = AW;
  int         mismatches  = 0;
  int         comparisons = 0;

  // Reference clock at 10 MHz; link clock at 160 ns with an odd phase.
  always #50 ref_clk = ~ref_clk;
  initial begin
    #33;
    forever #80 link_clk = ~link_clk;
  end

  // The data wire has a pull-up; either party may pull it low.
  assign sda_w = ~(sda_low | (sda_oe & ~sda_out));

  slp_host host (
    .ref_clk(ref_clk),
    .sda_w  (sda_w),
    .scl    (scl),
    .sda_low(sda_low)
  );

  slp_port uut (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .link_clk              (link_clk),
    .scl_pin               (scl),
    .sda_in                (sda_w),
    .sda_out               (sda_out),
    .sda_oe                (sda_oe),
    .select_or_addr0_pin   (pin0),
    .serial_in_or_addr1_pin(pin1),
    .gpio_strap_pin        (strap),
    .load_done             (load_done),
    .hotfix_done           (hotfix_done),
    .load_fail             (load_fail),
    .load_cfg_valid        (cfg_valid),
    .load_cfg              (load_cfg),
    .port_ready            (port_ready),
    .spi_selected          (spi_selected)
  );

  // Compares a seen value with the expected one and counts the result.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Sends bytes after a start, checking each acknowledge; optional stop.
  task automatic put(input logic [7:0] b[$], input logic fin, input logic nack);
    logic n;
    host.start();
    foreach (b[k]) begin
      host.wbyte(b[k], n);
      check("acknowledge", n, (k == 0) ? nack : 1'b0);
    end
    if (fin) host.stop();
  endtask

  // Repeated start, read address, then n bytes into rx and a stop.
  task automatic get(input int n);
    logic       a;
    logic [7:0] v;
    rx = {};
    host.start();
    host.wbyte(cur_aw | 8'h01, a);
    check("read acknowledge", a, 1'b0);
    for (int k = 0; k < n; k++) begin
      host.rbyte(k == n - 1, v);
      rx.push_back(v);
    end
    host.stop();
  endtask

  // Compares the bytes read with a little-endian expected value.
  task automatic chk_rx(input string what, input logic [31:0] e);
    foreach (rx[k]) check(what, rx[k], e[8*k+:8]);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (6) @(negedge ref_clk);
    check("ready in reset", port_ready, 1'b0);
    sys_rst = 1'b0;
    hotfix_done = 1'b1;
    put('{AW}, 1'b1, 1'b1);
    check("ready before load", port_ready, 1'b0);
    load_fail = 1'b1;
    load_done = 1'b1;
    @(negedge ref_clk);
    load_done = 1'b0;
    check("ready at load", port_ready, 1'b0);
    repeat (3) @(negedge ref_clk);
    check("ready after patch", port_ready, 1'b1);
    repeat (40) @(negedge ref_clk);
    done("reset sequence");
    for (int k = 1; k < 4; k++) put('{AW ^ (8'h01 << k)}, 1'b1, 1'b1);
    done("foreign addresses");
    put('{AW, 8'hfc}, 1'b0, 1'b0);
    get(4);
    chk_rx("page reset", `SLP_PAGE_RST);
    put('{AW, 8'hfc, 8'h00, 8'h80, 8'h00, 8'h00}, 1'b1, 1'b0);
    put('{AW, 8'he4, 8'h50, 8'h51}, 1'b1, 1'b0);
    put('{AW, 8'he4}, 1'b0, 1'b0);
    get(2);
    chk_rx("paged data", 32'h0000_5150);
    put('{AW, 8'hfc}, 1'b0, 1'b0);
    get(4);
    chk_rx("page", 32'h0000_8000);
    done("one byte offsets");
    put('{AW, 8'hfc, 8'h00, 8'hff, 8'h00, 8'h00}, 1'b1, 1'b0);
    put('{AW, 8'hf8}, 1'b0, 1'b0);
    get(2);
    chk_rx("setup and status", 32'h0000_0100);
    put('{AW, 8'hf8, 8'h01}, 1'b1, 1'b0);
    put('{AW, 8'h80, 8'he4}, 1'b0, 1'b0);
    get(2);
    chk_rx("full offset data", 32'h0000_5150);
    put('{AW, 8'h00, 8'h40, 8'ha5}, 1'b1, 1'b0);
    put('{AW, 8'h00, 8'h40}, 1'b0, 1'b0);
    get(1);
    chk_rx("lower half", 32'h0000_0000);
    put('{AW, 8'hff, 8'hfc}, 1'b0, 1'b0);
    get(4);
    chk_rx("page full offset", 32'h0000_ff00);
    done("two byte offsets");
    put('{AW, 8'hff, 8'hf8, 8'h03}, 1'b1, 1'b0);
    repeat (20) @(negedge ref_clk);
    check("protocol select", spi_selected, 1'b1);
    put('{AW}, 1'b1, 1'b1);
    done("protocol switch");
    sys_rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("ready in second reset", port_ready, 1'b0);
    check("protocol in reset", spi_selected, 1'b0);
    sys_rst = 1'b0;
    load_fail = 1'b0;
    cfg_valid = 1'b1;
    load_cfg = '{dev_base: LOADED, two_byte: 1'b1, spi_sel: 1'b0, fail: 1'b0};
    load_done = 1'b1;
    @(negedge ref_clk);
    load_done = 1'b0;
    repeat (40) @(negedge ref_clk);
    check("ready after reload", port_ready, 1'b1);
    put('{AW}, 1'b1, 1'b1);
    cur_aw = AW2;
    put('{AW2, 8'hff, 8'hf8}, 1'b0, 1'b0);
    get(2);
    chk_rx("loaded setup", 32'h0000_0001);
    done("loaded setup");
    results();
  end

  // Watchdog: cuts a hung run short well past the expected length.
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    results();
  end
endmodule  // slp_port_tb
